// ### rtl/serial_line.sv
// serial line receiver and transmitter with apb registers
//
// How it works
// - 5 or 8 data bits, both directions
// - receiver stop 0.5, 1.0, 1.5, 2.0 bits
// - receiver set half bit below sender
// - transmitter emits full configured stop bits
// - hold mode waits for mark before start
// - without hold, open line keeps raising flag
// - hold mode needs at least 1.5 stops
// - second or fourth pulse clears receive flag
// - bit clock 128x with divider, else 8x
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
module serial_line
   import serial_line_pkg::*;
#(
   parameter int div_width = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_line,
   output logic             tx_line,
   output logic             irq
);
   // refuse divider widths that the register word cannot carry
   if (div_width < 2 || div_width > 32) begin : g_bad_div_width
      $error("div_width out of range");
   end

   typedef enum {rx_idle, rx_start, rx_data, rx_stop, rx_wait_mark} rx_state_t;
   typedef enum {tx_idle, tx_start, tx_data, tx_stop} tx_state_t;

   logic [7:0]           ctrl_q;
   logic [div_width-1:0] div_q;
   logic [4:0]           status_q;
   logic [4:0]           mask_q;
   logic [7:0]           rxbuf_q;
   logic [7:0]           txsh_q;
   rx_state_t            rx_q;
   tx_state_t            tx_q;
   logic [6:0]           rx_cnt_q;
   logic [6:0]           tx_cnt_q;
   logic [2:0]           rx_bit_q;
   logic [2:0]           tx_bit_q;
   logic [7:0]           rx_sh_q;
   logic [1:0]           tx_half_q;
   logic                 tx_pend_q;
   logic [7:0]           tx_hold_q;

   // register access decode
   wire acc     = psel && penable;
   // a write lands on the edge at which the master sees pready high
   wire wr      = acc && pwrite && pready;
   wire hit_ctl = paddr == ctrl_offset;
   wire hit_div = paddr == div_offset;
   wire hit_txd = paddr == txdata_offset;
   wire hit_rxd = paddr == rxdata_offset;
   wire hit_st  = paddr == status_offset;
   wire hit_msk = paddr == mask_offset;
   wire hit_pls = paddr == pulse_offset;
   wire mapped  = hit_ctl | hit_div | hit_txd | hit_rxd | hit_st | hit_msk | hit_pls;

   wire       len8      = ctrl_q[ctrl_len8_bit];
   wire [1:0] rx_stop_code = ctrl_q[ctrl_rxstop_lsb +: 2];
   wire [1:0] tx_stop_code = ctrl_q[ctrl_txstop_lsb +: 2];
   wire       hold      = ctrl_q[ctrl_hold_bit];
   wire       clr_4th   = ctrl_q[ctrl_clr_fourth];
   wire       div_fit   = ctrl_q[ctrl_div_fitted];
   wire [2:0] last_bit  = len8 ? 3'h7 : 3'h4;
   wire [6:0] ovs_top   = div_fit ? 7'(ovs_divider - 1) : 7'(ovs_plain - 1);
   wire [6:0] ovs_mid   = div_fit ? 7'(ovs_divider / 2 - 1) : 7'(ovs_plain / 2 - 1);
   wire [6:0] half_top  = ovs_mid;

   // hold mode accepted only with long enough stop setting
   wire hold_ok = hold && (rx_stop_code == stop_onehalf || rx_stop_code == stop_two);

   logic tick;
   serial_bit_clock #(.width(div_width)) u_bit_clock (
      .pclk    (pclk),
      .presetn (presetn),
      .div     (div_q),
      .tick    (tick)
   );

   // receive flag clearing pulse selection
   wire pulse_wr  = wr && hit_pls;
   wire rx_clr    = pulse_wr && (clr_4th ? pwdata[pulse_fourth]
                                         : pwdata[pulse_second]);

   // ---------------- receiver ----------------
   wire rx_tick_end = tick && rx_cnt_q == ovs_top;
   wire rx_tick_mid = tick && rx_cnt_q == ovs_mid;
   // stop wait: half bits, measured from centre of last data bit
   logic [2:0] rx_stop_halves;
   always_comb begin
      unique case (rx_stop_code)
         stop_half:    rx_stop_halves = 3'h2;
         stop_one:     rx_stop_halves = 3'h3;
         stop_onehalf: rx_stop_halves = 3'h4;
         stop_two:     rx_stop_halves = 3'h5;
      endcase
   end
   logic [2:0] rx_half_q;
   wire rx_half_tick = tick && rx_cnt_q == half_top;
   logic rx_done;
   logic rx_ferr;
   assign rx_done = rx_q == rx_stop && rx_half_tick && (rx_half_q == rx_stop_halves - 3'h1);
   // mark sampled at the stop check; a short receiver stop resyncs early
   assign rx_ferr = rx_done && !rx_line;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q      <= rx_idle;
         rx_cnt_q  <= '0;
         rx_bit_q  <= '0;
         rx_sh_q   <= '0;
         rx_half_q <= '0;
      end else begin
         unique case (rx_q)
            rx_idle: begin
               rx_cnt_q <= '0;
               if (tick && !rx_line) rx_q <= rx_start;
            end
            rx_start: begin
               if (tick) rx_cnt_q <= rx_cnt_q + 7'h1;
               if (rx_tick_mid) begin
                  rx_cnt_q <= '0;
                  rx_bit_q <= '0;
                  rx_q     <= rx_line ? rx_idle : rx_data;
               end
            end
            rx_data: begin
               if (tick) rx_cnt_q <= rx_cnt_q + 7'h1;
               if (rx_tick_end) begin
                  rx_cnt_q <= '0;
                  rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == last_bit) begin
                     rx_q      <= rx_stop;
                     rx_half_q <= '0;
                  end
               end
            end
            rx_stop: begin
               if (tick) rx_cnt_q <= rx_half_tick ? 7'h0 : rx_cnt_q + 7'h1;
               if (rx_half_tick) rx_half_q <= rx_half_q + 3'h1;
               if (rx_done) begin
                  rx_q <= (hold_ok && !rx_line) ? rx_wait_mark : rx_idle;
               end
            end
            rx_wait_mark: begin
               if (tick && rx_line) rx_q <= rx_idle;
            end
            default: rx_q <= rx_idle;
         endcase
      end
   end

   wire [7:0] rx_char = len8 ? rx_sh_q : {3'h0, rx_sh_q[7:3]};

   // ---------------- transmitter ----------------
   wire tx_tick_end  = tick && tx_cnt_q == ovs_top;
   wire tx_half_end  = tick && tx_cnt_q == half_top;
   wire txd_wr       = wr && hit_txd && !tx_pend_q;
   // full stop bits on the line, counted in half bits
   wire [1:0] tx_halves_top = tx_stop_code;
   logic tx_done;
   assign tx_done = tx_q == tx_stop && tx_half_end && tx_half_q == tx_halves_top;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_q      <= tx_idle;
         tx_cnt_q  <= '0;
         tx_bit_q  <= '0;
         txsh_q    <= '0;
         tx_half_q <= '0;
         tx_line   <= 1'b1;
         tx_pend_q <= 1'b0;
         tx_hold_q <= '0;
      end else begin
         if (txd_wr) begin
            tx_pend_q <= 1'b1;
            tx_hold_q <= pwdata[7:0];
         end
         unique case (tx_q)
            tx_idle: begin
               tx_line  <= 1'b1;
               tx_cnt_q <= '0;
               if (tx_pend_q && tick) begin
                  txsh_q    <= tx_hold_q;
                  tx_pend_q <= 1'b0;
                  tx_line   <= 1'b0;
                  tx_q      <= tx_start;
               end
            end
            tx_start: begin
               if (tick) tx_cnt_q <= tx_cnt_q + 7'h1;
               if (tx_tick_end) begin
                  tx_cnt_q <= '0;
                  tx_bit_q <= '0;
                  tx_line  <= txsh_q[0];
                  txsh_q   <= {1'b0, txsh_q[7:1]};
                  tx_q     <= tx_data;
               end
            end
            tx_data: begin
               if (tick) tx_cnt_q <= tx_cnt_q + 7'h1;
               if (tx_tick_end) begin
                  tx_cnt_q <= '0;
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == last_bit) begin
                     tx_line   <= 1'b1;
                     tx_half_q <= '0;
                     tx_q      <= tx_stop;
                  end else begin
                     tx_line <= txsh_q[0];
                     txsh_q  <= {1'b0, txsh_q[7:1]};
                  end
               end
            end
            tx_stop: begin
               if (tick) tx_cnt_q <= tx_half_end ? 7'h0 : tx_cnt_q + 7'h1;
               if (tx_half_end) tx_half_q <= tx_half_q + 2'h1;
               if (tx_done) tx_q <= tx_idle;
            end
            default: tx_q <= tx_idle;
         endcase
      end
   end

   // ---------------- registers ----------------
   wire [4:0] events = {1'b0, (rx_done && status_q[st_rx_flag]), rx_ferr, tx_done, rx_done};
   wire [4:0] st_w1c = (wr && hit_st) ? pwdata[4:0] : 5'h0;
   wire [4:0] st_clr = st_w1c | {4'h0, rx_clr};
   wire [4:0] st_d   = (status_q & ~st_clr) | events;  // set wins over clear
   wire       busy   = tx_q != tx_idle || tx_pend_q;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (hit_ctl) rd_mux = {24'h0, ctrl_q};
      if (hit_div) rd_mux = 32'(div_q);
      if (hit_rxd) rd_mux = {24'h0, rxbuf_q};
      if (hit_st)  rd_mux = {27'h0, busy, status_q[3:0]};
      if (hit_msk) rd_mux = {27'h0, mask_q};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= ctrl_reset;
         div_q    <= div_width'(div_reset);
         status_q <= '0;
         mask_q   <= '0;
         rxbuf_q  <= '0;
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         irq      <= 1'b0;
      end else begin
         if (wr && hit_ctl) ctrl_q <= pwdata[7:0];
         if (wr && hit_div) div_q <= pwdata[div_width-1:0];
         if (wr && hit_msk) mask_q <= pwdata[4:0];
         if (rx_done) rxbuf_q <= rx_char;
         status_q <= {1'b0, st_d[3:0]};
         // one wait state: answer on second access cycle
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0;
         irq     <= |(st_d[3:0] & mask_q[3:0]);
      end
   end

   a_rx_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      rx_done |=> status_q[st_rx_flag])
      else $error("receive flag not set after stop check");
   a_rx_clr_sel: assert property (@(posedge pclk) disable iff (!presetn)
      rx_clr && !rx_done |=> !status_q[st_rx_flag])
      else $error("selected pulse did not clear receive flag");
   a_hold_wait: assert property (@(posedge pclk) disable iff (!presetn)
      rx_q == rx_wait_mark && !rx_line |=> rx_q == rx_wait_mark)
      else $error("receiver left hold before mark");
   a_hold_stop: assert property (@(posedge pclk) disable iff (!presetn)
      rx_q == rx_wait_mark |-> hold && rx_stop_code[1])
      else $error("hold used with short stop");
   a_tx_stop_mark: assert property (@(posedge pclk) disable iff (!presetn)
      tx_q == tx_stop |-> tx_line)
      else $error("stop interval not mark");
   a_tx_start_space: assert property (@(posedge pclk) disable iff (!presetn)
      tx_q == tx_start |-> !tx_line)
      else $error("start bit not space");
   a_len_bits: assert property (@(posedge pclk) disable iff (!presetn)
      rx_q == rx_data |-> rx_bit_q <= last_bit)
      else $error("receiver exceeded character length");
   a_open_rerun: assert property (@(posedge pclk) disable iff (!presetn)
      rx_done && !hold |=> rx_q == rx_idle)
      else $error("receiver did not rerun without hold");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      status_q[st_rx_flag] && mask_q[st_rx_flag] && $stable(status_q) && $stable(mask_q)
      |-> irq)
      else $error("irq low with unmasked flag");
endmodule : serial_line

// ### rtl/serial_line_pkg.sv
// constants for the serial line receiver and transmitter pair
package serial_line_pkg;
   localparam logic [7:0] ctrl_offset   = 8'h00;
   localparam logic [7:0] div_offset    = 8'h04;
   localparam logic [7:0] txdata_offset = 8'h08;
   localparam logic [7:0] rxdata_offset = 8'h0c;
   localparam logic [7:0] status_offset = 8'h10;
   localparam logic [7:0] mask_offset   = 8'h14;
   localparam logic [7:0] pulse_offset  = 8'h18;
   // control fields
   localparam int ctrl_len8_bit      = 0;
   localparam int ctrl_rxstop_lsb    = 1;
   localparam int ctrl_txstop_lsb    = 3;
   localparam int ctrl_hold_bit      = 5;
   localparam int ctrl_clr_fourth    = 6;
   localparam int ctrl_div_fitted    = 7;
   localparam logic [7:0] ctrl_reset = 8'h03;
   // stop lengths in half bits: code 0=0.5, 1=1.0, 2=1.5, 3=2.0
   localparam logic [1:0] stop_half  = 2'h0;
   localparam logic [1:0] stop_one   = 2'h1;
   localparam logic [1:0] stop_onehalf = 2'h2;
   localparam logic [1:0] stop_two   = 2'h3;
   // status bits
   localparam int st_rx_flag   = 0;
   localparam int st_tx_done   = 1;
   localparam int st_frame_err = 2;
   localparam int st_overrun   = 3;
   localparam int st_tx_busy   = 4;
   // pulse register bits
   localparam int pulse_second = 0;
   localparam int pulse_fourth = 1;
   // bit-clock oversampling
   localparam int ovs_divider = 128;
   localparam int ovs_plain   = 8;
   localparam logic [15:0] div_reset = 16'h0001;
endpackage : serial_line_pkg

// ### rtl/serial_bit_clock.sv
// bit-rate clock: a tick every div+1 cycles
`timescale 1ns/100ps
module serial_bit_clock #(
   parameter int width = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [width-1:0] div,
   output logic                  tick
);
   logic [width-1:0] cnt_q;
   wire              wrap = (cnt_q >= div);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= wrap ? '0 : cnt_q + 1'b1;
         tick  <= wrap;
      end
   end
endmodule : serial_bit_clock

// ### bench/serial_terminal.sv
// remote serial terminal model on the far side of the line
`timescale 1ns/100ps
module serial_terminal (
   input  wire logic pclk,
   input  wire logic tx_line,
   output wire logic rx_line
);
   logic line_q  = 1'b1;
   logic open_q  = 1'b0;
   int   bit_cyc = 16;
   // an open line reads as constant space
   assign rx_line = open_q ? 1'b0 : line_q;

   task automatic send(input logic [7:0] d, input int nbits, input int halves);
      @(posedge pclk);
      line_q <= 1'b0;
      repeat (bit_cyc) @(posedge pclk);
      for (int i = 0; i < nbits; i++) begin
         line_q <= d[i];
         repeat (bit_cyc) @(posedge pclk);
      end
      line_q <= 1'b1;
      repeat (halves * bit_cyc / 2) @(posedge pclk);
   endtask : send

   task automatic recv(input int nbits, input int nstop, output logic [7:0] d,
                       output logic ok);
      int n;
      n  = 0;
      d  = 8'h00;
      ok = 1'b1;
      while (tx_line !== 1'b0 && n < 4000) begin
         @(negedge pclk);
         n++;
      end
      repeat (bit_cyc / 2) @(negedge pclk);
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_cyc) @(negedge pclk);
         d[i] = tx_line;
      end
      for (int i = 0; i < nstop; i++) begin
         repeat (bit_cyc) @(negedge pclk);
         if (tx_line !== 1'b1) ok = 1'b0;
      end
   endtask : recv
endmodule : serial_terminal

// ### bench/tb_top.sv
// self-checking testbench for the serial line block
`timescale 1ns/100ps
module tb_top import serial_line_pkg::*; ;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   wire logic   rx_line;
   logic        tx_line;
   logic        irq;
   logic        err_q;
   logic [31:0] rv;
   logic [7:0]  bv;
   logic        sok;
   int          errors;
   int          checked;
   int          cycles;

   serial_line u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
   serial_terminal u_term (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_line));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // pready, prdata and pslverr are taken at the rising edge itself
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) errors++;
      rv    = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_bits(input int n);
      repeat (n * u_term.bit_cyc) @(posedge pclk);
   endtask : wait_bits

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (5) @(posedge pclk);
      check(32'(tx_line), 32'h1);
      presetn <= 1'b1;
      apb(1'b0, ctrl_offset, 32'h0);
      check(rv, 32'h03);
      apb(1'b0, div_offset, 32'h0);
      check(rv, 32'h1);
      apb(1'b0, 8'h1c, 32'h0);
      check({err_q, rv[30:0]}, 32'h80000000);
      apb(1'b1, mask_offset, 32'h1);
      // every receiver stop code, sender half a bit longer
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ctrl_offset, 32'(8'h01 | (c << 1)));
         u_term.send(8'h3c ^ 8'(c), 8, c + 2);
         repeat (4) @(posedge pclk);
         check(32'(irq), 32'h1);
         apb(1'b0, rxdata_offset, 32'h0);
         check(rv, 32'(8'h3c ^ c));
         apb(1'b0, status_offset, 32'h0);
         check(32'(rv[3:0]), 32'h1);
         apb(1'b1, mask_offset, 32'h0);
         repeat (2) @(posedge pclk);
         check(32'(irq), 32'h0);
         apb(1'b1, mask_offset, 32'h1);
         apb(1'b1, status_offset, 32'h1);
         repeat (2) @(posedge pclk);
         check(32'(irq), 32'h0);
      end
      apb(1'b1, ctrl_offset, 32'h02);
      u_term.send(8'h15, 5, 3);
      apb(1'b0, rxdata_offset, 32'h0);
      check(rv, 32'h15);
      u_term.send(8'h00, 8, 2);
      apb(1'b0, status_offset, 32'h0);
      check(32'(rv[st_frame_err]), 32'h1);
      wait_bits(12);
      apb(1'b1, status_offset, 32'hf);
      // only the selected pulse clears the receive flag
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, ctrl_offset, 32'(8'h03 | (f << 6)));
         u_term.send(8'h5a, 8, 3);
         apb(1'b1, pulse_offset, (f == 1) ? 32'h1 : 32'h2);
         apb(1'b0, status_offset, 32'h0);
         check(32'(rv[0]), 32'h1);
         apb(1'b1, pulse_offset, (f == 1) ? 32'h2 : 32'h1);
         apb(1'b0, status_offset, 32'h0);
         check(32'(rv[0]), 32'h0);
      end
      // open line: no hold, hold at 1.5 stops, hold at 1.0 stops
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, ctrl_offset, (k == 0) ? 32'h02 : ((k == 1) ? 32'h24 : 32'h22));
         u_term.open_q <= 1'b1;
         wait_bits(12);
         apb(1'b1, status_offset, 32'hf);
         wait_bits(10);
         apb(1'b0, status_offset, 32'h0);
         check(32'(rv[0]), 32'(k != 1));
         u_term.open_q <= 1'b0;
         wait_bits(12);
         apb(1'b1, status_offset, 32'hf);
      end
      apb(1'b1, ctrl_offset, 32'h19);
      fork
         u_term.recv(8, 2, bv, sok);
         apb(1'b1, txdata_offset, 32'ha5);
      join
      check(32'(bv), 32'ha5);
      check(32'(sok), 32'h1);
      apb(1'b0, status_offset, 32'h0);
      check(32'(rv[st_tx_busy]), 32'h1);
      wait_bits(2);
      apb(1'b0, status_offset, 32'h0);
      check(32'(rv[4:1]), 32'h1);
      apb(1'b1, ctrl_offset, 32'h8a);
      u_term.bit_cyc = 256;
      fork
         u_term.recv(5, 1, bv, sok);
         apb(1'b1, txdata_offset, 32'h1b);
      join
      check(32'(bv), 32'h1b);
      final_report();
   end
endmodule : tb_top
